/* rtl/misc_control_pin_logic.sv */
// Chip reset, config load, wake, GPIO, PHY reset, speed strap and LEDs
`timescale 1ns/1ps
`default_nettype none
module misc_control_pin_logic
  import misc_pins_pkg::*;
#(
  parameter int unsigned BLINK_CYC = BLINK_HALF_CYC
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  tick_12m,
  input  wire logic                  external_wake_request_low,
  output logic                       wake_event,
  input  wire logic                  full_speed_only_strap,
  input  wire logic                  hs_handshake_ok,
  output logic                       chirp_enable,
  output logic                       high_speed,
  input  wire logic                  bulk_out_busy,
  output logic                       activity_indicator,
  output logic                       bus_speed_indicator,
  input  wire logic [GPIO_W-1:0]     gpio_in,
  input  wire logic [GPIO_W-1:0]     sw_gpio_oe,
  input  wire logic [GPIO_W-1:0]     sw_gpio_out,
  input  wire logic                  sw_gpio_wr,
  output logic [GPIO_W-1:0]          gpio_out,
  output logic [GPIO_W-1:0]          gpio_oe,
  output logic [GPIO_W-1:0]          gpio_val,
  input  wire logic                  sw_phy_rst_drive,
  input  wire logic                  sw_phy_rst_level,
  input  wire logic                  sw_phy_rst_wr,
  output logic                       ext_transceiver_reset_out,
  output logic                       ext_transceiver_reset_oe,
  output logic                       cfg_rd_req,
  output logic [CFG_ADDR_W-1:0]      cfg_rd_addr,
  input  wire logic                  cfg_rd_ack,
  output logic                       cfg_loaded,
  input  wire logic [DEBUG_W-1:0]    debug_inputs,
  output logic                       debug_active
);
  logic        rst;
  load_state_t ld_state_ff;
  logic        wake_pulse;

  // Reset is async; both edges go straight to the flops
  assign rst = ~rst_n;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ld_state_ff <= LD_IDLE;
      cfg_rd_req  <= 1'b0;
      cfg_rd_addr <= 8'h00;
      cfg_loaded  <= 1'b0;
    end else begin
      unique case (ld_state_ff)
        LD_IDLE: begin
          cfg_rd_req  <= 1'b1;
          ld_state_ff <= LD_REQ;
        end
        LD_REQ: begin
          if (cfg_rd_ack) begin
            cfg_rd_req <= 1'b0;
            if (cfg_rd_addr == 8'(CFG_WORDS - 1)) begin
              ld_state_ff <= LD_DONE;
              cfg_loaded  <= 1'b1;
            end else begin
              cfg_rd_addr <= cfg_rd_addr + 8'h01;
              ld_state_ff <= LD_WAIT;
            end
          end
        end
        LD_WAIT: begin
          cfg_rd_req  <= 1'b1;
          ld_state_ff <= LD_REQ;
        end
        LD_DONE: begin
          cfg_rd_req <= 1'b0;
        end
      endcase
    end
  end

  // Strap sampled after release, not under reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chirp_enable <= 1'b0;
      high_speed   <= 1'b0;
    end else begin
      chirp_enable <= full_speed_only_strap;
      high_speed   <= full_speed_only_strap & hs_handshake_ok;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gpio_oe  <= GPIO_OE_RST;
      gpio_out <= 3'h0;
      gpio_val <= 3'h0;
    end else begin
      gpio_val <= gpio_in;
      if (sw_gpio_wr) begin
        gpio_oe  <= sw_gpio_oe;
        gpio_out <= sw_gpio_out;
      end
    end
  end

  // Undriven after reset keeps the PHY held by its board resistor
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_transceiver_reset_oe  <= 1'b0;
      ext_transceiver_reset_out <= 1'b0;
    end else if (sw_phy_rst_wr) begin
      ext_transceiver_reset_oe  <= sw_phy_rst_drive;
      ext_transceiver_reset_out <= sw_phy_rst_level;
    end
  end

  // Nonzero debug inputs only flagged; board must tie them low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      debug_active <= 1'b0;
    end else begin
      debug_active <= |debug_inputs;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wake_event <= 1'b0;
    end else begin
      wake_event <= wake_pulse;
    end
  end

  wake_qualifier #(
    .MIN_CYC (WAKE_MIN_PERIODS)
  ) u_wake (
    .clk        (clk),
    .rst        (rst),
    .tick_12m   (tick_12m),
    .wake_low   (external_wake_request_low),
    .wake_pulse (wake_pulse)
  );

  activity_blinker #(
    .HALF_CYC (BLINK_CYC)
  ) u_led (
    .clk                 (clk),
    .rst                 (rst),
    .high_speed          (high_speed),
    .bulk_out_busy       (bulk_out_busy),
    .activity_indicator  (activity_indicator),
    .bus_speed_indicator (bus_speed_indicator)
  );

  sequence load_start_s;
    ld_state_ff == LD_IDLE;
  endsequence

  sequence load_req_s;
    cfg_rd_req && cfg_rd_addr == 8'h00;
  endsequence

  load_auto_a: assert property (@(posedge clk) disable iff (rst)
    load_start_s |=> load_req_s) else $error("load did not start");
  gpio_input_a: assert property (@(posedge clk) disable iff (rst)
    !sw_gpio_wr && gpio_oe == 3'h0 |=> gpio_oe == 3'h0) else $error("gpio oe moved");
  phy_hold_a: assert property (@(posedge clk) disable iff (rst)
    !sw_phy_rst_wr |=> $stable(ext_transceiver_reset_oe)) else $error("phy oe moved");
  phy_cmd_a: assert property (@(posedge clk) disable iff (rst)
    sw_phy_rst_wr |=> ext_transceiver_reset_oe == $past(sw_phy_rst_drive))
    else $error("phy cmd ignored");
  fs_only_a: assert property (@(posedge clk) disable iff (rst)
    !full_speed_only_strap |=> !chirp_enable && !high_speed) else $error("chirp in fs");
  hs_run_a: assert property (@(posedge clk) disable iff (rst)
    full_speed_only_strap |=> chirp_enable) else $error("no handshake");
  wake_out_a: assert property (@(posedge clk) disable iff (rst)
    wake_pulse |=> wake_event) else $error("wake lost");
  debug_flag_a: assert property (@(posedge clk) disable iff (rst)
    debug_inputs != 5'h00 |=> debug_active) else $error("debug flag");
endmodule
`default_nettype wire

/* rtl/misc_pins_pkg.sv */
// Shared constants for the control-pin block
package misc_pins_pkg;
  localparam int unsigned CLK_HZ           = 250_000_000;
  localparam int unsigned WAKE_CLK_HZ      = 12_000_000;
  // Wake low must last more than this many 12 MHz periods
  localparam int unsigned WAKE_MIN_PERIODS = 2;
  localparam int unsigned WAKE_MIN_CYCLES  =
    (WAKE_MIN_PERIODS * CLK_HZ + WAKE_CLK_HZ - 1) / WAKE_CLK_HZ;
  // Blink half period, in microseconds
  localparam int unsigned BLINK_HALF_US    = 100_000;
  localparam int unsigned BLINK_HALF_CYC   = BLINK_HALF_US * (CLK_HZ / 1_000_000);
  localparam int unsigned GPIO_W           = 3;
  localparam int unsigned DEBUG_W          = 5;
  localparam int unsigned CFG_ADDR_W       = 8;
  localparam int unsigned CFG_WORDS        = 21;
  localparam logic [GPIO_W-1:0] GPIO_OE_RST = 3'h0;
  typedef enum logic [1:0] {LD_IDLE, LD_REQ, LD_WAIT, LD_DONE} load_state_t;
endpackage

/* rtl/wake_qualifier.sv */
// Wake input synchroniser and low-time qualifier
`timescale 1ns/1ps
`default_nettype none
module wake_qualifier
  import misc_pins_pkg::*;
#(
  // Counted in 12 MHz periods, not in clk cycles
  parameter int unsigned MIN_CYC = WAKE_MIN_PERIODS
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic tick_12m,
  input  wire logic wake_low,
  output logic      wake_pulse
);
  logic        sync1_ff;
  logic        sync2_ff;
  logic [15:0] low_cnt_ff;
  logic        fired_ff;

  // First stage feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_ff <= 1'b1;
      sync2_ff <= 1'b1;
    end else begin
      sync1_ff <= wake_low;
      sync2_ff <= sync1_ff;
    end
  end

  // Low on MIN_CYC+1 ticks in a row spans more than MIN_CYC periods
  // Only tick samples count; a blip high between ticks goes unseen
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_cnt_ff <= 16'h0000;
      fired_ff   <= 1'b0;
      wake_pulse <= 1'b0;
    end else begin
      wake_pulse <= 1'b0;
      if (tick_12m) begin
        if (sync2_ff) begin
          low_cnt_ff <= 16'h0000;
          fired_ff   <= 1'b0;
        end else if (!fired_ff) begin
          if (low_cnt_ff >= 16'(MIN_CYC)) begin
            fired_ff   <= 1'b1;
            wake_pulse <= 1'b1;
          end else begin
            low_cnt_ff <= low_cnt_ff + 16'h0001;
          end
        end
      end
    end
  end

  wake_once_a: assert property (@(posedge clk) disable iff (rst)
    wake_pulse |=> !wake_pulse) else $error("wake pulse too long");
  wake_high_a: assert property (@(posedge clk) disable iff (rst)
    wake_pulse |-> $past(tick_12m && !sync2_ff)) else $error("wake while high");
endmodule
`default_nettype wire

/* rtl/activity_blinker.sv */
// Speed and traffic indicator drivers
`timescale 1ns/1ps
`default_nettype none
module activity_blinker
  import misc_pins_pkg::*;
#(
  parameter int unsigned HALF_CYC = BLINK_HALF_CYC
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic high_speed,
  input  wire logic bulk_out_busy,
  output logic      activity_indicator,
  output logic      bus_speed_indicator
);
  logic [31:0] div_ff;
  logic        phase_ff;

  // Fixed divided interval keeps the blink visible
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_ff   <= 32'h0000_0000;
      phase_ff <= 1'b0;
    end else if (!bulk_out_busy) begin
      div_ff   <= 32'h0000_0000;
      phase_ff <= 1'b0;
    end else if (div_ff >= 32'(HALF_CYC - 1)) begin
      div_ff   <= 32'h0000_0000;
      phase_ff <= ~phase_ff;
    end else begin
      div_ff <= div_ff + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      activity_indicator  <= 1'b1;
      bus_speed_indicator <= 1'b1;
    end else begin
      bus_speed_indicator <= ~high_speed;
      if (bulk_out_busy) begin
        activity_indicator <= phase_ff ^ high_speed;
      end else begin
        activity_indicator <= ~high_speed;
      end
    end
  end

  speed_led_a: assert property (@(posedge clk) disable iff (rst)
    ##1 bus_speed_indicator == !$past(high_speed)) else $error("speed led wrong");
  idle_led_a: assert property (@(posedge clk) disable iff (rst)
    !bulk_out_busy |=> activity_indicator == !$past(high_speed)) else $error("idle led");
endmodule
`default_nettype wire

/* bench/cfg_mem_model.sv */
// Serial configuration memory model answering word reads
`timescale 1ns/1ps
`default_nettype none
module cfg_mem_model
  import misc_pins_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  cfg_rd_req,
  input  wire logic [CFG_ADDR_W-1:0] cfg_rd_addr,
  output logic                       cfg_rd_ack,
  output logic [7:0]                 words,
  output logic                       order_err
);
  logic [3:0] wait_ff;
  // Odd words answer slowly, even words at once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rd_ack <= 1'b0;
      wait_ff <= 4'h0;
      words <= 8'h00;
      order_err <= 1'b0;
    end else if (cfg_rd_ack) begin
      cfg_rd_ack <= 1'b0;
    end else if (cfg_rd_req && wait_ff >= (words[0] ? 4'h3 : 4'h0)) begin
      cfg_rd_ack <= 1'b1;
      wait_ff <= 4'h0;
      words <= words + 8'h01;
      order_err <= order_err | (cfg_rd_addr !== words);
    end else if (cfg_rd_req) begin
      wait_ff <= wait_ff + 4'h1;
    end
  end
endmodule
`default_nettype wire

/* bench/testbench.sv */
// Self-checking bench for the control-pin block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import misc_pins_pkg::*;
  logic clk, rst_n, wake_n, strap, hs_ok, busy, gwr, pdrive, plevel, pwr, ack;
  logic tick_12m = 1'b0;
  logic [4:0] dbg_in;
  logic wake_event, chirp, hs, act, spd, req, loaded, dbg_act, poe, pout, oerr;
  logic [2:0] gpio_in, g_oe_sw, g_out_sw, g_out, g_oe, g_val;
  logic [7:0] addr, words;
  int error_cnt, total_checks;
  int wake_cnt = 0;
  int tick_cnt = 0;

  misc_control_pin_logic #(.BLINK_CYC(8)) misc_control_pin_logic_i (
    .clk(clk), .rst_n(rst_n), .tick_12m(tick_12m), .external_wake_request_low(wake_n),
    .wake_event(wake_event), .full_speed_only_strap(strap), .hs_handshake_ok(hs_ok),
    .chirp_enable(chirp), .high_speed(hs), .bulk_out_busy(busy),
    .activity_indicator(act), .bus_speed_indicator(spd), .gpio_in(gpio_in),
    .sw_gpio_oe(g_oe_sw), .sw_gpio_out(g_out_sw), .sw_gpio_wr(gwr), .gpio_out(g_out),
    .gpio_oe(g_oe), .gpio_val(g_val), .sw_phy_rst_drive(pdrive), .sw_phy_rst_level(plevel),
    .sw_phy_rst_wr(pwr), .ext_transceiver_reset_out(pout), .ext_transceiver_reset_oe(poe),
    .cfg_rd_req(req), .cfg_rd_addr(addr), .cfg_rd_ack(ack), .cfg_loaded(loaded),
    .debug_inputs(dbg_in), .debug_active(dbg_act));
  cfg_mem_model cfg_mem_model_i (.clk(clk), .rst_n(rst_n), .cfg_rd_req(req),
    .cfg_rd_addr(addr), .cfg_rd_ack(ack), .words(words), .order_err(oerr));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Roughly 12 MHz tick, one pulse every 21 cycles
  always @(posedge clk) begin
    tick_cnt <= (tick_cnt == 20) ? 0 : tick_cnt + 1;
    tick_12m <= (tick_cnt == 20);
    if (wake_event === 1'b1) wake_cnt <= wake_cnt + 1;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Reset with a given strap; checks during reset and the automatic load
  task automatic t_reset(input logic s);
    @(posedge clk);
    rst_n <= 1'b0;
    strap <= s;
    #1;
    chk({1'b0, poe, g_oe, act, spd, wake_event}, 8'h06);
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 400 && loaded !== 1'b1; i++) @(posedge clk);
    #1;
    chk({7'h0, loaded}, 8'h01);
    chk(words, 8'h15);
    chk({7'h0, oerr}, 8'h00);
    repeat (3) @(posedge clk);
    #1;
  endtask
  // Strap, handshake result and the expected {chirp, hs, speed led, activity}
  task automatic t_speed(input logic s, input logic h, input logic [7:0] exp);
    @(posedge clk);
    hs_ok <= h;
    t_reset(s);
    chk({4'h0, chirp, hs, spd, act}, exp);
  endtask
  task automatic t_blink;
    logic prev;
    int n;
    t_reset(1'b1);
    @(posedge clk);
    busy <= 1'b1;
    prev = act;
    for (n = 0; n < 40 && act === prev; n++) @(posedge clk) #1;
    prev = act;
    n = 0;
    do begin
      @(posedge clk) #1;
      n++;
    end while (act === prev && n < 40);
    chk(n[7:0], 8'h08);
    chk({7'h0, spd}, 8'h00);
    @(posedge clk);
    busy <= 1'b0;
    repeat (20) @(posedge clk);
    #1;
    chk({7'h0, act}, 8'h00);
  endtask
  // A short low is refused, a long low fires once
  task automatic t_wake;
    int base;
    base = wake_cnt;
    @(posedge clk);
    wake_n <= 1'b0;
    repeat (30) @(posedge clk);
    wake_n <= 1'b1;
    repeat (100) @(posedge clk);
    chk(8'(wake_cnt - base), 8'h00);
    wake_n <= 1'b0;
    repeat (120) @(posedge clk);
    wake_n <= 1'b1;
    repeat (60) @(posedge clk);
    chk(8'(wake_cnt - base), 8'h01);
  endtask
  task automatic t_ctrl;
    @(posedge clk);
    pdrive <= 1'b1;
    g_oe_sw <= 3'h5;
    g_out_sw <= 3'h3;
    gpio_in <= 3'h6;
    dbg_in <= 5'h04;
    repeat (5) @(posedge clk);
    #1;
    chk({4'h0, poe, g_oe}, 8'h00);
    chk({5'h0, g_val}, 8'h06);
    chk({7'h0, dbg_act}, 8'h01);
    @(posedge clk);
    pwr <= 1'b1;
    gwr <= 1'b1;
    dbg_in <= 5'h00;
    @(posedge clk);
    pwr <= 1'b0;
    gwr <= 1'b0;
    @(posedge clk) #1;
    chk({poe, pout, g_oe, g_out}, 8'heb);
    chk({7'h0, dbg_act}, 8'h00);
    @(posedge clk);
    pdrive <= 1'b0;
    pwr <= 1'b1;
    @(posedge clk);
    pwr <= 1'b0;
    @(posedge clk) #1;
    chk({6'h0, poe, pout}, 8'h01);
  endtask

  initial begin
    {rst_n, wake_n, strap, hs_ok} = 4'h7;
    dbg_in = 5'h00;
    {busy, gwr, pdrive, plevel, pwr} = 5'h0;
    {gpio_in, g_oe_sw, g_out_sw} = 9'h0;
    error_cnt = 0;
    total_checks = 0;
    plevel = 1'b1;
    t_speed(1'b0, 1'b1, 8'h03);
    t_speed(1'b1, 1'b0, 8'h0b);
    t_speed(1'b1, 1'b1, 8'h0c);
    t_blink();
    t_wake();
    t_ctrl();
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    stop_test();
  end
endmodule
`default_nettype wire
